// ### verilog/bcrb_pkg.sv
// Package: address map, field layout and types for the board control register bank
`default_nettype none
package bcrb_pkg;
   // Board control window
   localparam logic [31:0] BCRB_WIN_BASE = 32'hffe00000;
   localparam logic [31:0] BCRB_WIN_LAST = 32'hffe7ffff;
   // Register byte addresses
   localparam logic [31:0] BCRB_ADDR_BOARD_IDENTIFIER   = 32'hffe00010;
   localparam logic [31:0] BCRB_ADDR_COMPAT     = 32'hffe00012;
   localparam logic [31:0] BCRB_ADDR_MEMCFG     = 32'hffe00014;
   localparam logic [31:0] BCRB_ADDR_FLASH_PAGE = 32'hffe00016;
   localparam logic [31:0] BCRB_ADDR_NVRAM_PAGE = 32'hffe00017;
   localparam logic [31:0] BCRB_ADDR_WDOG       = 32'hffe00018;
   localparam logic [31:0] BCRB_ADDR_IRQ_EN     = 32'hffe00019;
   localparam logic [31:0] BCRB_ADDR_CONTROL    = 32'hffe0001a;
   localparam logic [31:0] BCRB_ADDR_SWITCH     = 32'hffe0001b;
   localparam logic [31:0] BCRB_ADDR_EVENT      = 32'hffe0001c;
   localparam logic [31:0] BCRB_ADDR_REVISION   = 32'hffe0001e;
   // Memory configuration fields
   localparam int BCRB_MEMCFG_ECC_BIT  = 4;
   localparam int BCRB_MEMCFG_BOOT_BIT = 7;
   // Memory size codes
   localparam logic [1:0] BCRB_SZ_32MB  = 2'h0;
   localparam logic [1:0] BCRB_SZ_64MB  = 2'h1;
   localparam logic [1:0] BCRB_SZ_256MB = 2'h2;
   localparam logic [1:0] BCRB_SZ_128MB = 2'h3;
   // Reset values and miss answer
   localparam logic [7:0] BCRB_ZERO_BYTE  = 8'h00;
   localparam logic [3:0] BCRB_FLASH_MASK = 4'hf;
   localparam logic [1:0] BCRB_NVRAM_MASK = 2'h3;
   // Host bus request
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        single_byte;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } bcrb_req_type;
   // Board straps
   typedef struct packed {
      logic [1:0] mem_size_code;
      logic       ecc_enabled;
      logic       boot_select_jumper;
   } bcrb_strap_type;
endpackage
`default_nettype wire

// ### verilog/bcrb_bank.sv
// Board control register bank: byte-wide decoder and register file
//
// Contract
// [RULE_01] Host uses single-byte transfers; device decodes only the board control window.
// [RULE_02] Board identifier is a fixed read-only byte; writes change nothing.
// [RULE_03] Software compatibility level is a read-only factory byte.
// [RULE_04] Memory configuration bits 1:0 give installed memory size code.
// [RULE_05] Memory configuration bit 4 shows whether memory error correction is active.
// [RULE_06] Bit 7 shows boot jumper: zero fitted boot socket, one onboard flash.
// [RULE_07] Upper area writes must be single-byte; wider writes are not supported.
// [RULE_08] Reserved bits read zero; writes to read-only registers have no effect.
`default_nettype none
module bcrb_bank
   import bcrb_pkg::*;
#(
   parameter logic [7:0] BOARD_IDENTIFIER_VALUE  = 8'h5a, // Arbitrary identity value
   parameter logic [7:0] COMPAT_LEVEL    = 8'h00,
   parameter logic [7:0] HW_REVISION     = 8'h01  // Arbitrary revision value
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_n,
   // Host byte bus
   input  wire bcrb_req_type   req,
   output logic                ack,
   output logic [7:0]          rdata,
   output logic                hit,
   // Board straps and inputs
   input  wire bcrb_strap_type strap,
   input  wire logic [7:0]     rotary_switch,
   // Register outputs to board logic
   output logic [3:0]          flash_page,
   output logic [1:0]          nvram_page,
   output logic [7:0]          watchdog_ctrl,
   output logic [7:0]          irq_enable,
   output logic [7:0]          board_ctrl,
   output logic [7:0]          event_flags
);

   logic       in_window;
   logic       acc_ok;
   logic       wr_ok;
   logic [7:0] rd_mux;
   logic [7:0] memcfg_byte;
   logic [3:0] flash_page_reg;
   logic [1:0] nvram_page_reg;
   logic [7:0] watchdog_reg;
   logic [7:0] irq_en_reg;
   logic [7:0] control_reg;
   logic [7:0] event_reg;
   logic [7:0] rdata_reg;
   logic       ack_reg;
   logic       hit_reg;

   // Window decode used by both read and write paths
   function automatic logic win_hit(input logic [31:0] a);
      win_hit = (a >= BCRB_WIN_BASE) && (a <= BCRB_WIN_LAST);
   endfunction

   // Only single-byte transfers inside the window are served
   assign in_window = win_hit(req.addr);                                  // [RULE_01]
   assign acc_ok    = req.valid && in_window && req.single_byte;          // [RULE_01]
   // Wider writes are dropped rather than split, keeping the bank simple
   assign wr_ok     = acc_ok && req.write;                                // [RULE_07]

   // Memory configuration built live from straps, reserved bits zero
   always_comb begin
      memcfg_byte                       = BCRB_ZERO_BYTE;                 // [RULE_08]
      memcfg_byte[1:0]                  = strap.mem_size_code;            // [RULE_04]
      memcfg_byte[BCRB_MEMCFG_ECC_BIT]  = strap.ecc_enabled;              // [RULE_05]
      memcfg_byte[BCRB_MEMCFG_BOOT_BIT] = strap.boot_select_jumper;       // [RULE_06]
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      unique case (req.addr)
         BCRB_ADDR_BOARD_IDENTIFIER:   rd_mux = BOARD_IDENTIFIER_VALUE;                   // [RULE_02]
         BCRB_ADDR_COMPAT:     rd_mux = COMPAT_LEVEL;                     // [RULE_03]
         BCRB_ADDR_MEMCFG:     rd_mux = memcfg_byte;
         BCRB_ADDR_FLASH_PAGE: rd_mux = {4'h0, flash_page_reg};           // [RULE_08]
         BCRB_ADDR_NVRAM_PAGE: rd_mux = {6'h00, nvram_page_reg};          // [RULE_08]
         BCRB_ADDR_WDOG:       rd_mux = watchdog_reg;
         BCRB_ADDR_IRQ_EN:     rd_mux = irq_en_reg;
         BCRB_ADDR_CONTROL:    rd_mux = control_reg;
         BCRB_ADDR_SWITCH:     rd_mux = rotary_switch;
         BCRB_ADDR_EVENT:      rd_mux = event_reg;
         BCRB_ADDR_REVISION:   rd_mux = HW_REVISION;
         default:              rd_mux = BCRB_ZERO_BYTE;
      endcase
   end

   // Writable registers; read-only addresses fall through untouched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_page_reg <= BCRB_FLASH_MASK & 4'h0;
         nvram_page_reg <= BCRB_NVRAM_MASK & 2'h0;
         watchdog_reg   <= BCRB_ZERO_BYTE;
         irq_en_reg     <= BCRB_ZERO_BYTE;
         control_reg    <= BCRB_ZERO_BYTE;
         event_reg      <= BCRB_ZERO_BYTE;
      end else if (wr_ok) begin
         unique case (req.addr)
            BCRB_ADDR_FLASH_PAGE: flash_page_reg <= req.wdata[3:0] & BCRB_FLASH_MASK;
            BCRB_ADDR_NVRAM_PAGE: nvram_page_reg <= req.wdata[1:0] & BCRB_NVRAM_MASK;
            BCRB_ADDR_WDOG:       watchdog_reg   <= req.wdata;
            BCRB_ADDR_IRQ_EN:     irq_en_reg     <= req.wdata;
            BCRB_ADDR_CONTROL:    control_reg    <= req.wdata;
            BCRB_ADDR_EVENT:      event_reg      <= req.wdata;
            default:              ;                                       // [RULE_08]
         endcase
      end
   end

   // Bus answer: one cycle after each request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg   <= 1'b0;
         hit_reg   <= 1'b0;
         rdata_reg <= BCRB_ZERO_BYTE;
      end else begin
         ack_reg   <= req.valid;
         hit_reg   <= acc_ok;
         rdata_reg <= (acc_ok && !req.write) ? rd_mux : BCRB_ZERO_BYTE;   // [RULE_01]
      end
   end

   assign ack           = ack_reg;
   assign hit           = hit_reg;
   assign rdata         = rdata_reg;
   assign flash_page    = flash_page_reg;
   assign nvram_page    = nvram_page_reg;
   assign watchdog_ctrl = watchdog_reg;
   assign irq_enable    = irq_en_reg;
   assign board_ctrl    = control_reg;
   assign event_flags   = event_reg;

   // Read sequence and its answer
   sequence s_read_req(logic [31:0] a);
      req.valid && !req.write && req.single_byte && req.addr == a;
   endsequence

   property p_board_identifier;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_BOARD_IDENTIFIER) |=> rdata == BOARD_IDENTIFIER_VALUE && hit;
   endproperty
   a_board_identifier: assert property (p_board_identifier) else $error("board_identifier wrong"); // [RULE_02]

   property p_compat;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_COMPAT) |=> rdata == COMPAT_LEVEL;
   endproperty
   a_compat: assert property (p_compat) else $error("compat level wrong"); // [RULE_03]

   property p_mem_size;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_MEMCFG) |=> rdata[1:0] == $past(strap.mem_size_code);
   endproperty
   a_mem_size: assert property (p_mem_size) else $error("size code wrong"); // [RULE_04]

   property p_ecc;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_MEMCFG) |=> rdata[BCRB_MEMCFG_ECC_BIT] == $past(strap.ecc_enabled);
   endproperty
   a_ecc: assert property (p_ecc) else $error("ecc bit wrong"); // [RULE_05]

   property p_boot;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_MEMCFG)
         |=> rdata[BCRB_MEMCFG_BOOT_BIT] == $past(strap.boot_select_jumper);
   endproperty
   a_boot: assert property (p_boot) else $error("boot bit wrong"); // [RULE_06]

   property p_reserved;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_MEMCFG) |=> rdata[6:5] == 2'h0 && rdata[3:2] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set"); // [RULE_08]

   property p_outside;
      @(posedge clk) disable iff (!rst_n)
      req.valid && !win_hit(req.addr) |=> !hit && rdata == BCRB_ZERO_BYTE;
   endproperty
   a_outside: assert property (p_outside) else $error("decode outside window"); // [RULE_01]

   property p_wide_write;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.write && !req.single_byte |=> $stable(flash_page) && $stable(board_ctrl);
   endproperty
   a_wide_write: assert property (p_wide_write) else $error("wide write took"); // [RULE_07]

   property p_flash_write;
      @(posedge clk) disable iff (!rst_n)
      wr_ok && req.addr == BCRB_ADDR_FLASH_PAGE |=> flash_page == $past(req.wdata[3:0]);
   endproperty
   a_flash_write: assert property (p_flash_write) else $error("flash page lost"); // [RULE_01]

   // Write sequence, the mirror of the read one
   sequence s_write_req(logic [31:0] a);
      req.valid && req.write && req.single_byte && req.addr == a;
   endsequence

   // Every request gets exactly one answer, one cycle later
   property p_ack_pulse;
      @(posedge clk) disable iff (!rst_n)
      req.valid |=> ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack missing"); // [RULE_01]

   // Idle cycles must not produce a stray answer
   property p_no_ack;
      @(posedge clk) disable iff (!rst_n)
      !req.valid |=> !ack && !hit;
   endproperty
   a_no_ack: assert property (p_no_ack) else $error("stray ack"); // [RULE_01]

   // Byte access inside the window is always claimed
   property p_hit_decode;
      @(posedge clk) disable iff (!rst_n)
      req.valid && win_hit(req.addr) && req.single_byte |=> hit;
   endproperty
   a_hit_decode: assert property (p_hit_decode) else $error("window miss"); // [RULE_01]

   // Wider transfers are answered but never claimed
   property p_wide_refused;
      @(posedge clk) disable iff (!rst_n)
      req.valid && !req.single_byte |=> !hit && rdata == BCRB_ZERO_BYTE;
   endproperty
   a_wide_refused: assert property (p_wide_refused) else $error("wide access taken"); // [RULE_07]

   // Writes return no data, so a host cannot mistake them for reads
   property p_write_quiet;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.write |=> rdata == BCRB_ZERO_BYTE;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("write returned data"); // [RULE_01]

   property p_nvram_write;
      @(posedge clk) disable iff (!rst_n)
      s_write_req(BCRB_ADDR_NVRAM_PAGE) |=> nvram_page == $past(req.wdata[1:0]);
   endproperty
   a_nvram_write: assert property (p_nvram_write) else $error("nvram page lost"); // [RULE_01]

   property p_wdog_write;
      @(posedge clk) disable iff (!rst_n)
      s_write_req(BCRB_ADDR_WDOG) |=> watchdog_ctrl == $past(req.wdata);
   endproperty
   a_wdog_write: assert property (p_wdog_write) else $error("watchdog byte lost"); // [RULE_01]

   property p_irq_write;
      @(posedge clk) disable iff (!rst_n)
      s_write_req(BCRB_ADDR_IRQ_EN) |=> irq_enable == $past(req.wdata);
   endproperty
   a_irq_write: assert property (p_irq_write) else $error("irq enable lost"); // [RULE_01]

   property p_ctrl_write;
      @(posedge clk) disable iff (!rst_n)
      s_write_req(BCRB_ADDR_CONTROL) |=> board_ctrl == $past(req.wdata);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control byte lost"); // [RULE_01]

   property p_event_write;
      @(posedge clk) disable iff (!rst_n)
      s_write_req(BCRB_ADDR_EVENT) |=> event_flags == $past(req.wdata);
   endproperty
   a_event_write: assert property (p_event_write) else $error("event byte lost"); // [RULE_01]

   // Writes to read-only bytes must leave every writable byte alone
   property p_ro_write;
      @(posedge clk) disable iff (!rst_n)
      wr_ok && (req.addr == BCRB_ADDR_BOARD_IDENTIFIER || req.addr == BCRB_ADDR_COMPAT
         || req.addr == BCRB_ADDR_MEMCFG || req.addr == BCRB_ADDR_SWITCH
         || req.addr == BCRB_ADDR_REVISION)
         |=> $stable(flash_page) && $stable(nvram_page) && $stable(watchdog_ctrl)
            && $stable(irq_enable) && $stable(board_ctrl) && $stable(event_flags);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write took"); // [RULE_08]

   // Writes outside the window must not alias onto the bank
   property p_outside_write;
      @(posedge clk) disable iff (!rst_n)
      req.valid && req.write && !win_hit(req.addr)
         |=> $stable(flash_page) && $stable(nvram_page) && $stable(event_flags);
   endproperty
   a_outside_write: assert property (p_outside_write) else $error("alias write"); // [RULE_01]

   // Narrow page registers pad with zeros on read
   property p_flash_pad;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_FLASH_PAGE) |=> rdata[7:4] == 4'h0;
   endproperty
   a_flash_pad: assert property (p_flash_pad) else $error("flash pad set"); // [RULE_08]

   property p_nvram_pad;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_NVRAM_PAGE) |=> rdata[7:2] == 6'h00;
   endproperty
   a_nvram_pad: assert property (p_nvram_pad) else $error("nvram pad set"); // [RULE_08]

   // Switch byte is passed live, as seen at the request edge
   property p_switch_read;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_SWITCH) |=> rdata == $past(rotary_switch);
   endproperty
   a_switch_read: assert property (p_switch_read) else $error("switch byte wrong"); // [RULE_01]

   // Revision byte is fixed like the identifier
   property p_revision;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(BCRB_ADDR_REVISION) |=> rdata == HW_REVISION && hit;
   endproperty
   a_revision: assert property (p_revision) else $error("revision wrong"); // [RULE_08]

endmodule
`default_nettype wire

// ### verification/bcrb_host_model.sv
// Host bus master model issuing single-byte or wider requests to the register bank
`default_nettype none
module bcrb_host_model
   import bcrb_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Request and answer
   output var bcrb_req_type req,
   input  wire logic       ack,
   input  wire logic       hit,
   input  wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // One request held over its taking edge; released lines show inverted junk
   task automatic xfer(input logic w, sb, input logic [31:0] a, input logic [7:0] d,
                       output logic a_o, h_o, output logic [7:0] r_o);
      @(posedge clk);
      #2;
      req = '{valid: 1'b1, write: w, single_byte: sb, addr: a, wdata: d};
      @(posedge clk);
      #2;
      req = '{valid: 1'b0, write: ~w, single_byte: ~sb, addr: ~a, wdata: ~d};
      a_o = ack;
      h_o = hit;
      r_o = rdata;
   endtask
endmodule
`default_nettype wire

// ### verification/bcrb_bank_tb_top.sv
// Self-checking bench for the board control register bank
`default_nettype none
module bcrb_bank_tb_top
   import bcrb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value
   localparam logic [7:0] CL = 8'h02;
   localparam logic [7:0] RV = 8'h07; // Arbitrary revision value
   logic           clk, rst_n, ack, hit, a_o, h_o;
   logic [7:0]     rdata, r_o, rotary_switch, watchdog_ctrl, irq_enable, board_ctrl, event_flags;
   logic [3:0]     flash_page;
   logic [1:0]     nvram_page;
   bcrb_req_type   req;
   bcrb_strap_type strap;
   int             mismatches, n_checks;
   bcrb_bank #(.BOARD_IDENTIFIER_VALUE(ID), .COMPAT_LEVEL(CL), .HW_REVISION(RV)) dut (
      .clk(clk), .rst_n(rst_n), .req(req), .ack(ack), .rdata(rdata), .hit(hit), .strap(strap),
      .rotary_switch(rotary_switch), .flash_page(flash_page), .nvram_page(nvram_page),
      .watchdog_ctrl(watchdog_ctrl), .irq_enable(irq_enable), .board_ctrl(board_ctrl),
      .event_flags(event_flags));
   bcrb_host_model host (.clk(clk), .req(req), .ack(ack), .hit(hit), .rdata(rdata));
   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One access, then compare of ack, hit and read data
   task automatic acc(input logic w, sb, input logic [31:0] a, input logic [7:0] d,
                      input logic eh, input logic [7:0] er);
      host.xfer(w, sb, a, d, a_o, h_o, r_o);
      chk({7'h00, a_o}, 8'h01);
      chk({7'h00, h_o}, {7'h00, eh});
      chk(r_o, er);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard, far beyond the few microseconds the tests need
   initial begin
      #50us;
      mismatches++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      strap = '0;
      rotary_switch = 8'h96;
      mismatches = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      #2 rst_n = 1'b1;
      acc(0, 1, BCRB_ADDR_BOARD_IDENTIFIER, 8'h00, 1, ID);
      acc(1, 1, BCRB_ADDR_BOARD_IDENTIFIER, 8'h11, 1, 8'h00);
      acc(0, 1, BCRB_ADDR_BOARD_IDENTIFIER, 8'h00, 1, ID);
      acc(1, 1, BCRB_ADDR_COMPAT, 8'hff, 1, 8'h00);
      acc(0, 1, BCRB_ADDR_COMPAT, 8'h00, 1, CL);
      acc(0, 1, BCRB_ADDR_REVISION, 8'h00, 1, RV);
      acc(1, 1, BCRB_ADDR_SWITCH, 8'h00, 1, 8'h00);
      acc(0, 1, BCRB_ADDR_SWITCH, 8'h00, 1, 8'h96);
      // Every size code, with error correction and jumper both ways
      for (int i = 0; i < 16; i++) begin
         strap = bcrb_strap_type'(i[3:0]);
         acc(0, 1, BCRB_ADDR_MEMCFG, 8'h00, 1, {strap.boot_select_jumper, 2'b00,
             strap.ecc_enabled, 2'b00, strap.mem_size_code});
      end
      // Window edges and refused requests
      acc(0, 1, 32'hffe7ffff, 8'h00, 1, 8'h00);
      acc(0, 1, 32'hffe80000, 8'h00, 0, 8'h00);
      acc(0, 1, 32'hffdfffff, 8'h00, 0, 8'h00);
      acc(1, 1, BCRB_ADDR_FLASH_PAGE, 8'hf5, 1, 8'h00);
      acc(0, 1, BCRB_ADDR_FLASH_PAGE, 8'h00, 1, 8'h05);
      acc(1, 0, BCRB_ADDR_FLASH_PAGE, 8'h0a, 0, 8'h00);
      acc(1, 1, 32'hffe80016, 8'h0a, 0, 8'h00);
      chk({4'h0, flash_page}, 8'h05);
      acc(1, 1, BCRB_ADDR_NVRAM_PAGE, 8'hfe, 1, 8'h00);
      acc(0, 0, BCRB_ADDR_NVRAM_PAGE, 8'h00, 0, 8'h00);
      acc(0, 1, BCRB_ADDR_NVRAM_PAGE, 8'h00, 1, 8'h02);
      chk({6'h00, nvram_page}, 8'h02);
      acc(1, 1, BCRB_ADDR_WDOG, 8'ha5, 1, 8'h00);
      acc(1, 1, BCRB_ADDR_IRQ_EN, 8'h3c, 1, 8'h00);
      acc(1, 1, BCRB_ADDR_CONTROL, 8'hc3, 1, 8'h00);
      acc(1, 1, BCRB_ADDR_EVENT, 8'h5a, 1, 8'h00);
      acc(0, 1, BCRB_ADDR_EVENT, 8'h00, 1, 8'h5a);
      chk(watchdog_ctrl, 8'ha5);
      chk(irq_enable, 8'h3c);
      chk(board_ctrl, 8'hc3);
      chk(event_flags, 8'h5a);
      // Reset in mid-run clears the writable bytes at once
      rst_n = 1'b0;
      #3;
      chk(watchdog_ctrl, 8'h00);
      chk({4'h0, flash_page}, 8'h00);
      @(posedge clk);
      #2 rst_n = 1'b1;
      acc(0, 1, BCRB_ADDR_BOARD_IDENTIFIER, 8'h00, 1, ID);
      results();
   end
endmodule
`default_nettype wire
